// File: verilog/mox_pkg.sv
/*
  mox_pkg: opcode patterns, field positions, widths and phase encoding
  for the move / store / or execution block.
  assumes a 14-bit instruction word and an 8-bit data path.
*/
package mox_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 7;

  // ---------------------------------------------------------------
  // instruction fields
  // ---------------------------------------------------------------
  localparam int OPC_HI   = 13;
  localparam int OPC_LO   = 8;
  localparam int DEST_BIT = 7;
  localparam int ADDR_HI  = 6;

  localparam logic [5:0] OPC_MOVE_FILE = 6'h08;
  localparam logic [5:0] OPC_OR_FILE   = 6'h04;
  localparam logic [5:0] OPC_ZERO_GRP  = 6'h00;
  localparam logic [1:0] OPC_LIT_GRP   = 2'h3;
  localparam logic [1:0] OPC_LIT_MOVE  = 2'h0;

  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 7'h00;

  // ---------------------------------------------------------------
  // quarter phases, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    MOX_Q1 = 4'b0001,
    MOX_Q2 = 4'b0010,
    MOX_Q3 = 4'b0100,
    MOX_Q4 = 4'b1000
  } mox_phase_e;

  // decoded operation kinds
  typedef enum logic [2:0] {
    MOX_OP_IDLE  = 3'h0,
    MOX_OP_MOVE  = 3'h1,
    MOX_OP_STORE = 3'h2,
    MOX_OP_OR    = 3'h3,
    MOX_OP_LIT   = 3'h4
  } mox_op_e;

endpackage : mox_pkg

// File: verilog/mox_decode.sv
/*
  mox_decode: combinational opcode classifier.
  assumes the instruction word is stable while it is sampled.
*/
`timescale 1ns/1ps
module mox_decode
  import mox_pkg::*;
(
  input  wire logic [INSTR_W-1:0] i_instr,
  output mox_op_e                 o_op
);

  always_comb begin
    o_op = MOX_OP_IDLE;
    if (i_instr[OPC_HI:OPC_LO] == OPC_MOVE_FILE) begin
      o_op = MOX_OP_MOVE;
    end else if (i_instr[OPC_HI:OPC_LO] == OPC_OR_FILE) begin
      o_op = MOX_OP_OR;
    end else if (i_instr[OPC_HI:OPC_LO] == OPC_ZERO_GRP && i_instr[DEST_BIT]) begin
      o_op = MOX_OP_STORE;
    end else if (i_instr[OPC_HI:OPC_HI-1] == OPC_LIT_GRP
                 && i_instr[OPC_HI-2:OPC_HI-3] == OPC_LIT_MOVE) begin
      o_op = MOX_OP_LIT;
    end
  end

endmodule : mox_decode

// File: verilog/mox_exec.sv
/*
  mox_exec: four-phase executor for move-file, store-working,
  or-with-file and load-literal; anything else runs as idle.
  assumes the file register array answers a read address combinationally
  and takes one write strobe in the fourth quarter.
*/
// Operation
// - move file value unchanged to destination
// - dest bit low to working, high back
// - move file updates zero flag
// - store working into file, flags untouched
// - one cycle, decode read process write
`timescale 1ns/1ps
module mox_exec
  import mox_pkg::*;
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  input  wire logic [INSTR_W-1:0] i_instr,
  input  wire logic [DATA_W-1:0]  i_file_rdata,
  output logic      [ADDR_W-1:0]  o_file_addr,
  output logic      [DATA_W-1:0]  o_file_wdata,
  output logic                    o_file_we,
  output logic      [DATA_W-1:0]  o_work,
  output logic                    o_zero,
  output logic                    o_cycle_done
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  mox_phase_e             phase_r,   phase_nxt;
  mox_op_e                op_r,      op_nxt;
  mox_op_e                dec_op;
  logic                   dest_r,    dest_nxt;
  logic [DATA_W-1:0]      lit_r,     lit_nxt;
  logic [DATA_W-1:0]      opnd_r,    opnd_nxt;
  logic [DATA_W-1:0]      res_r,     res_nxt;
  logic [ADDR_W-1:0]      addr_r,    addr_nxt;
  logic [DATA_W-1:0]      wdata_r,   wdata_nxt;
  logic                   we_r,      we_nxt;
  logic [DATA_W-1:0]      work_r,    work_nxt;
  logic                   zero_r,    zero_nxt;
  logic                   done_r,    done_nxt;
  logic                   in_q1;
  logic                   in_q2;
  logic                   in_q3;
  logic                   in_q4;

  mox_decode u_decode (
    .i_instr (i_instr),
    .o_op    (dec_op)
  );

  // ---------------------------------------------------------------
  // quarter decode
  // ---------------------------------------------------------------
  assign in_q1 = (phase_r == MOX_Q1);
  assign in_q2 = (phase_r == MOX_Q2);
  assign in_q3 = (phase_r == MOX_Q3);
  assign in_q4 = (phase_r == MOX_Q4);

  // ---------------------------------------------------------------
  // phase sequencer
  // ---------------------------------------------------------------
  always_comb begin
    case (phase_r)
      MOX_Q1:  phase_nxt = MOX_Q2;
      MOX_Q2:  phase_nxt = MOX_Q3;
      MOX_Q3:  phase_nxt = MOX_Q4;
      MOX_Q4:  phase_nxt = MOX_Q1;
      default: phase_nxt = MOX_Q1;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_r <= MOX_Q1;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // ---------------------------------------------------------------
  // instruction latch: decode quarter only, so a word that changes
  // later in the cycle cannot disturb the running instruction
  // ---------------------------------------------------------------
  always_comb begin
    op_nxt   = op_r;
    dest_nxt = dest_r;
    lit_nxt  = lit_r;
    addr_nxt = addr_r;
    if (in_q1) begin
      op_nxt   = dec_op;
      dest_nxt = i_instr[DEST_BIT];
      lit_nxt  = i_instr[DATA_W-1:0];
      addr_nxt = i_instr[ADDR_HI:0];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      op_r   <= MOX_OP_IDLE;
      dest_r <= 1'b0;
      lit_r  <= DATA_ZERO;
      addr_r <= ADDR_ZERO;
    end else begin
      op_r   <= op_nxt;
      dest_r <= dest_nxt;
      lit_r  <= lit_nxt;
      addr_r <= addr_nxt;
    end
  end

  // ---------------------------------------------------------------
  // operand read and processing
  // ---------------------------------------------------------------
  always_comb begin
    opnd_nxt = opnd_r;
    res_nxt  = res_r;
    if (in_q2) begin
      // file operand sampled once, held through the write quarter
      opnd_nxt = i_file_rdata;
    end
    if (in_q3) begin
      case (op_r)
        MOX_OP_MOVE:  res_nxt = opnd_r;
        MOX_OP_OR:    res_nxt = work_r | opnd_r;
        MOX_OP_STORE: res_nxt = work_r;
        MOX_OP_LIT:   res_nxt = lit_r;
        default:      res_nxt = res_r;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      opnd_r <= DATA_ZERO;
      res_r  <= DATA_ZERO;
    end else begin
      opnd_r <= opnd_nxt;
      res_r  <= res_nxt;
    end
  end

  // ---------------------------------------------------------------
  // working register and zero flag
  // ---------------------------------------------------------------
  always_comb begin
    work_nxt = work_r;
    zero_nxt = zero_r;
    if (in_q4) begin
      case (op_r)
        MOX_OP_MOVE, MOX_OP_OR: begin
          zero_nxt = (res_r == DATA_ZERO);
          if (!dest_r) begin
            work_nxt = res_r;
          end
        end
        // literal load leaves the zero flag alone; store must too
        MOX_OP_LIT: work_nxt = res_r;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      work_r <= DATA_ZERO;
      zero_r <= 1'b0;
    end else begin
      work_r <= work_nxt;
      zero_r <= zero_nxt;
    end
  end

  // ---------------------------------------------------------------
  // file write and cycle end strobes
  // ---------------------------------------------------------------
  always_comb begin
    wdata_nxt = wdata_r;
    we_nxt    = 1'b0;
    done_nxt  = 1'b0;
    if (in_q4) begin
      case (op_r)
        MOX_OP_MOVE, MOX_OP_OR: begin
          if (dest_r) begin
            wdata_nxt = res_r;
            we_nxt    = 1'b1;
          end
        end
        MOX_OP_STORE: begin
          // zero flag deliberately left alone
          wdata_nxt = res_r;
          we_nxt    = 1'b1;
        end
        default: ;
      endcase
      done_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wdata_r <= DATA_ZERO;
      we_r    <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      wdata_r <= wdata_nxt;
      we_r    <= we_nxt;
      done_r  <= done_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all registered
  // ---------------------------------------------------------------
  assign o_file_addr  = addr_r;
  assign o_file_wdata = wdata_r;
  assign o_file_we    = we_r;
  assign o_work       = work_r;
  assign o_zero       = zero_r;
  assign o_cycle_done = done_r;

endmodule : mox_exec

// File: tb/mox_exec_sva.sv
/* checker for mox_exec: phase timing and results.
   assumes first edge after reset is a decode edge. */
`timescale 1ns/1ps
module mox_exec_sva
  import mox_pkg::*;
(
  input wire logic               i_ref_clk,
  input wire logic               i_rst,
  input wire logic [INSTR_W-1:0] i_instr,
  input wire logic [DATA_W-1:0]  i_file_rdata,
  input wire logic [ADDR_W-1:0]  o_file_addr,
  input wire logic [DATA_W-1:0]  o_file_wdata,
  input wire logic               o_file_we,
  input wire logic [DATA_W-1:0]  o_work,
  input wire logic               o_zero,
  input wire logic               o_cycle_done
);
  // ---------------------------------------------
  // phase counter, mirrors the quarter sequence
  // ---------------------------------------------
  logic [1:0] ph_r;
  logic [1:0] ph_nxt;
  logic       q1;
  logic [5:0] opc;
  always_comb ph_nxt = ph_r + 2'h1;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) ph_r <= 2'h0;
    else ph_r <= ph_nxt;
  end
  assign q1  = (ph_r == 2'h0);
  assign opc = i_instr[OPC_HI:OPC_LO];
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_addr_latch: assert property (q1 |=> o_file_addr == $past(i_instr[6:0]))
    else $error("file address not latched");
  a_move_work: assert property (q1 && opc == OPC_MOVE_FILE && !i_instr[7] ##1 1
    |-> ##3 o_work == $past(i_file_rdata, 3) && !o_file_we) else $error("move to work wrong");
  a_move_zero: assert property (q1 && opc == OPC_MOVE_FILE ##1 1
    |-> ##3 o_zero == ($past(i_file_rdata, 3) == DATA_ZERO)) else $error("move zero flag wrong");
  a_move_back: assert property (q1 && opc == OPC_MOVE_FILE && i_instr[7] ##1 1
    |-> ##3 o_file_we && o_file_wdata == $past(i_file_rdata, 3) && $stable(o_work))
    else $error("move back to file wrong");
  a_store_copy: assert property (q1 && i_instr[13:7] == {OPC_ZERO_GRP, 1'b1}
    |-> ##4 o_file_we && o_file_wdata == $past(o_work, 4) && o_zero == $past(o_zero, 4))
    else $error("store working wrong");
  a_or_result: assert property (q1 && opc == OPC_OR_FILE && !i_instr[7] ##1 1
    |-> ##3 o_work == ($past(o_work, 3) | $past(i_file_rdata, 3))
    && o_zero == (o_work == DATA_ZERO)) else $error("or result wrong");
  a_done_spacing: assert property (o_cycle_done |=> !o_cycle_done [*3] ##1 o_cycle_done)
    else $error("instruction cycle not four quarters");
  a_we_in_done: assert property (o_file_we |-> o_cycle_done)
    else $error("write outside fourth quarter");
endmodule : mox_exec_sva
bind mox_exec mox_exec_sva u_sva (.i_ref_clk, .i_rst, .i_instr, .i_file_rdata, .o_file_addr,
  .o_file_wdata, .o_file_we, .o_work, .o_zero, .o_cycle_done);

// File: tb/test_move_or_instr_exec.sv
/* testbench for mox_exec: one instruction per four clocks.
   assumes a combinational file answered by the bench. */
`timescale 1ns/1ps
module test_move_or_instr_exec
  import mox_pkg::*;
;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [INSTR_W-1:0] ins = 14'h0000;
  logic [DATA_W-1:0]  rd  = 8'h00;
  logic [ADDR_W-1:0]  addr;
  logic [DATA_W-1:0]  wd, work;
  logic               we, z, done;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  mox_exec DUT (.i_ref_clk(clk), .i_rst(rst), .i_instr(ins), .i_file_rdata(rd),
    .o_file_addr(addr), .o_file_wdata(wd), .o_file_we(we), .o_work(work), .o_zero(z),
    .o_cycle_done(done));
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  initial forever #2.5 clk = ~clk;
  task automatic give_verdict();
    $display("checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  // drives one instruction, returns in the cycle its results stand
  task automatic run(input logic [INSTR_W-1:0] i, input logic [DATA_W-1:0] d);
    ins = i;
    rd  = d;
    @(posedge clk);
    #1 chk(addr === i[6:0], "address");
    repeat (3) @(posedge clk);
    #1 chk(done === 1'b1, "done");
  endtask : run
  task automatic t_move();
    run(14'h3000 | 14'h005a, 8'h00);
    run(14'h0805, 8'h00);
    chk(work === 8'h00 && z === 1'b1 && we === 1'b0, "move to work");
    run(14'h0885, 8'h3c);
    chk(we === 1'b1 && wd === 8'h3c && z === 1'b0 && work === 8'h00, "move back");
  endtask : t_move
  task automatic t_store();
    run(14'h3000 | 14'h005a, 8'h00);
    run(14'h0891, 8'h00);
    chk(we === 1'b1 && wd === 8'h00 && z === 1'b1 && work === 8'h5a, "move zero");
    run(14'h0092, 8'hff);
    chk(we === 1'b1 && wd === 8'h5a && z === 1'b1, "store");
  endtask : t_store
  task automatic t_or();
    run(14'h0407, 8'h81);
    chk(work === 8'hdb && z === 1'b0 && we === 1'b0, "or to work");
    run(14'h3000, 8'h00);
    run(14'h0487, 8'h00);
    chk(we === 1'b1 && wd === 8'h00 && z === 1'b1, "or back");
    run(14'h0000, 8'h77);
    chk(we === 1'b0 && work === 8'h00, "idle");
  endtask : t_or
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    t_move();
    t_store();
    t_or();
    give_verdict();
  end
endmodule : test_move_or_instr_exec
